// ==== rtl/sfc_pkg.sv ====
// Package for the fabric-side lane controller: constants, types, states.
// Assumes a lane hard block with active-low resets and ready outputs.
// Functional notes
// - PCS resets come from one source, released after hard reset delay.
// - Power-on inputs for RX, synth, TX asserted an interval after power-up.
// - RX logic on recovered RX clock, TX logic on TX clock; unrelated.
// - Configuration-bus clock must run when the device is configured.
// - Loopback is enabled at run time by a PCS write over config bus.
// - Access-complete pulses one cycle; requester captures read data then.
// - External loopback: omit controller or set mode disabling loopback.
// - Data generator produces 40-bit words containing comma characters.
// - Generator runs on lane TX clock, reset by the lane TX reset.
// - Generation enabled only when transmit ready reports ready.
// - In reset or disabled, output comma code in alternate 10-bit slots.
package sfc_pkg;
    // APB register offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] ADDR_OFS   = 8'h08;
    localparam logic [7:0] WDATA_OFS  = 8'h0C;
    localparam logic [7:0] RDATA_OFS  = 8'h10;
    // Control field positions
    localparam int CTRL_RUN_BIT   = 0;
    localparam int CTRL_LBDIS_BIT = 1;
    localparam int CTRL_REQ_BIT   = 2;
    localparam int CTRL_WR_BIT    = 3;
    localparam int CTRL_PMA_BIT   = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    // Sequencing times (ns) and cycle counts at 200 MHz
    localparam int CLK_NS        = 5;
    localparam int POWER_ON_NS   = 1000;
    localparam int HARD_REL_NS   = 1000;
    localparam int PCS_REL_NS    = 1000;
    localparam int POWER_ON_CYC  = (POWER_ON_NS + CLK_NS - 1) / CLK_NS;
    localparam int HARD_REL_CYC  = (HARD_REL_NS + CLK_NS - 1) / CLK_NS;
    localparam int PCS_REL_CYC   = (PCS_REL_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    // Transmit comma word
    localparam logic [9:0]  COMMA_CODE = 10'h1BC;
    localparam logic [39:0] COMMA_WORD = {10'h000, COMMA_CODE, 10'h000, COMMA_CODE};
    localparam logic [6:0]  PRBS_SEED  = 7'h7F;
    localparam logic [3:0]  COMMA_GAP  = 4'hF;
    // Reset sequence states
    typedef enum logic [3:0] {
        SEQ_OFF   = 4'b0001,
        SEQ_POWER = 4'b0010,
        SEQ_HARD  = 4'b0100,
        SEQ_RUN   = 4'b1000
    } sfc_seq_t;
    // Ready status bundle from lane
    typedef struct packed {
        logic synth;
        logic tx;
        logic rx;
        logic align;
    } sfc_ready_t;
    // Pass-through request toward loopback controller
    typedef struct packed {
        logic        req;
        logic        write;
        logic        pma;
        logic [15:0] addr;
        logic [15:0] wdata;
    } sfc_pass_t;
endpackage

// ==== rtl/sfc_ctrl.sv ====
// Fabric controller for one lane: reset sequencer, TX data generator, APB regs.
// Assumes lane hard block and loopback controller outside; pins are async.
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
module sfc_ctrl (
    // Clock and reset
    input  wire logic                clk_in,
    input  wire logic                rst_n_in,
    input  wire logic                lane_tx_clock_in,
    // APB slave
    input  wire logic                psel_in,
    input  wire logic                penable_in,
    input  wire logic                pwrite_in,
    input  wire logic [7:0]          paddr_in,
    input  wire logic [31:0]         pwdata_in,
    output logic [31:0]              prdata_out,
    output logic                     pready_out,
    output logic                     pslverr_out,
    // Lane resets and power
    output logic                     pma_hard_reset_n_out,
    output logic                     rx_pcs_reset_n_out,
    output logic                     tx_pcs_reset_n_out,
    output logic                     rx_power_on_n_out,
    output logic                     synth_power_on_n_out,
    output logic                     tx_power_on_n_out,
    // Lane status
    input  wire logic                lane_tx_ready_in,
    input  wire logic                lane_synth_ready_in,
    input  wire logic                lane_rx_ready_in,
    input  wire logic                align_locked_in,
    // Transmit data on TX clock
    output logic [39:0]              lane_tx_word_out,
    // Loopback controller side
    output logic                     loopback_disable_out,
    output sfc_pkg::sfc_pass_t       pass_out,
    input  wire logic                lb_done_in,
    input  wire logic                pass_valid_in,
    input  wire logic [15:0]         pass_rdata_in
);
    sfc_pkg::sfc_seq_t   state;
    logic [15:0]         cnt;
    logic [4:0]          ctrl;
    logic [15:0]         addr_reg;
    logic [15:0]         wdata_reg;
    logic [15:0]         rdata_reg;
    logic                busy;
    logic [2:0]          s_synth;
    logic [2:0]          s_tx;
    logic [2:0]          s_rx;
    logic [2:0]          s_align;
    logic [2:0]          s_done;
    logic [2:0]          s_valid;
    logic [2:0][15:0]    s_rdata;
    logic                spent;
    logic [3:0]          rdy;
    logic                done_st;
    logic                valid_st;
    logic                valid_q;
    logic                apb_wr;
    logic                apb_rd;
    logic [31:0]         next_rdata;
    logic                run;

    // Three-stage synchronisers; a level change counted when stages 2 and 3 agree, the completion pulse by its edge
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s_synth <= 3'h0;
            s_tx    <= 3'h0;
            s_rx    <= 3'h0;
            s_align <= 3'h0;
            s_done  <= 3'h0;
            s_valid <= 3'h0;
            s_rdata <= '0;
        end else begin
            s_synth <= {s_synth[1:0], lane_synth_ready_in};
            s_tx    <= {s_tx[1:0], lane_tx_ready_in};
            s_rx    <= {s_rx[1:0], lane_rx_ready_in};
            s_align <= {s_align[1:0], align_locked_in};
            s_done  <= {s_done[1:0], lb_done_in};
            s_valid <= {s_valid[1:0], pass_valid_in};
            // Read data travels in step with the completion pulse
            s_rdata <= {s_rdata[1:0], pass_rdata_in};
        end
    end

    // Filtered status levels
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rdy      <= 4'h0;
            done_st  <= 1'b0;
            valid_st <= 1'b0;
        end else begin
            if (s_synth[1] == s_synth[2]) rdy[3] <= s_synth[2];
            if (s_tx[1] == s_tx[2])       rdy[2] <= s_tx[2];
            if (s_rx[1] == s_rx[2])       rdy[1] <= s_rx[2];
            if (s_align[1] == s_align[2]) rdy[0] <= s_align[2];
            if (s_done[1] == s_done[2])   done_st <= s_done[2];
            // One-cycle completion pulse never settles in two stages: take its edge
            valid_st <= s_valid[1] && !s_valid[2];
        end
    end

    assign run = ctrl[sfc_pkg::CTRL_RUN_BIT];

    // Reset sequence: power on, then hard reset release, then PCS release
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !run) begin
            state <= sfc_pkg::SEQ_OFF;
            cnt   <= sfc_pkg::CNT_ZERO;
        end else begin
            case (state)
                sfc_pkg::SEQ_OFF: begin
                    if (cnt == 16'(sfc_pkg::POWER_ON_CYC - 1)) begin
                        state <= sfc_pkg::SEQ_POWER;
                        cnt   <= sfc_pkg::CNT_ZERO;
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                sfc_pkg::SEQ_POWER: begin
                    if (cnt == 16'(sfc_pkg::HARD_REL_CYC - 1)) begin
                        state <= sfc_pkg::SEQ_HARD;
                        cnt   <= sfc_pkg::CNT_ZERO;
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                sfc_pkg::SEQ_HARD: begin
                    if (cnt == 16'(sfc_pkg::PCS_REL_CYC - 1)) begin
                        state <= sfc_pkg::SEQ_RUN;
                        cnt   <= sfc_pkg::CNT_ZERO;
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                sfc_pkg::SEQ_RUN: state <= sfc_pkg::SEQ_RUN;
                default: state <= sfc_pkg::SEQ_OFF;
            endcase
        end
    end

    // Reset and power pins, registered
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rx_power_on_n_out    <= 1'b0;
            synth_power_on_n_out <= 1'b0;
            tx_power_on_n_out    <= 1'b0;
            pma_hard_reset_n_out <= 1'b0;
            rx_pcs_reset_n_out   <= 1'b0;
            tx_pcs_reset_n_out   <= 1'b0;
        end else begin
            rx_power_on_n_out    <= (state != sfc_pkg::SEQ_OFF);
            synth_power_on_n_out <= (state != sfc_pkg::SEQ_OFF);
            tx_power_on_n_out    <= (state != sfc_pkg::SEQ_OFF);
            pma_hard_reset_n_out <= (state == sfc_pkg::SEQ_HARD) || (state == sfc_pkg::SEQ_RUN);
            rx_pcs_reset_n_out   <= (state == sfc_pkg::SEQ_RUN);
            tx_pcs_reset_n_out   <= (state == sfc_pkg::SEQ_RUN);
        end
    end

    // APB access, zero wait states
    assign pready_out  = 1'b1;
    assign apb_wr      = psel_in && penable_in && pwrite_in;
    assign apb_rd      = psel_in && !pwrite_in;
    assign pslverr_out = psel_in && penable_in && (paddr_in > sfc_pkg::RDATA_OFS);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ctrl      <= sfc_pkg::CTRL_RESET;
            addr_reg  <= 16'h0000;
            wdata_reg <= 16'h0000;
        end else begin
            if (apb_wr && paddr_in == sfc_pkg::CTRL_OFS) ctrl <= pwdata_in[4:0];
            if (apb_wr && paddr_in == sfc_pkg::ADDR_OFS) addr_reg <= pwdata_in[15:0];
            if (apb_wr && paddr_in == sfc_pkg::WDATA_OFS) wdata_reg <= pwdata_in[15:0];
        end
    end

    // Pass-through request, two-cycle pulse; raised only while done
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pass_out             <= '0;
            loopback_disable_out <= 1'b0;
        end else begin
            loopback_disable_out <= ctrl[sfc_pkg::CTRL_LBDIS_BIT];
            pass_out.req   <= ctrl[sfc_pkg::CTRL_REQ_BIT] && done_st && !busy && !spent;
            pass_out.write <= ctrl[sfc_pkg::CTRL_WR_BIT];
            pass_out.pma   <= ctrl[sfc_pkg::CTRL_PMA_BIT];
            pass_out.addr  <= addr_reg;
            pass_out.wdata <= wdata_reg;
        end
    end

    // Access tracking and read data capture on completion pulse
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            busy      <= 1'b0;
            spent     <= 1'b0;
            valid_q   <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            valid_q <= valid_st;
            if (valid_st && !valid_q) begin
                busy      <= 1'b0;
                rdata_reg <= s_rdata[2];
            end else if (pass_out.req) begin
                busy <= 1'b1;
            end
            // One access per request bit; software clears it before the next
            if (!ctrl[sfc_pkg::CTRL_REQ_BIT]) spent <= 1'b0;
            else if (pass_out.req) spent <= 1'b1;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (apb_rd) begin
            case (paddr_in)
                sfc_pkg::CTRL_OFS:   next_rdata = {27'h000_0000, ctrl};
                sfc_pkg::STATUS_OFS: next_rdata = {22'h00_0000, busy, done_st, rdy, state};
                sfc_pkg::ADDR_OFS:   next_rdata = {16'h0000, addr_reg};
                sfc_pkg::WDATA_OFS:  next_rdata = {16'h0000, wdata_reg};
                sfc_pkg::RDATA_OFS:  next_rdata = {16'h0000, rdata_reg};
                default:             next_rdata = 32'h0000_0000;
            endcase
        end
    end
    assign prdata_out = next_rdata;

    // Transmit domain: TX ready and PCS reset synchronised to lane TX clock
    logic [2:0]  t_rst;
    logic [2:0]  t_rdy;
    logic        t_en;
    logic [6:0]  prbs;
    logic [3:0]  gap;

    // Lane TX reset asserts at once and releases through the chain
    always_ff @(posedge lane_tx_clock_in or negedge tx_pcs_reset_n_out) begin
        if (!tx_pcs_reset_n_out) begin
            t_rst <= 3'h0;
            t_rdy <= 3'h0;
            t_en  <= 1'b0;
        end else begin
            t_rst <= {t_rst[1:0], 1'b1};
            t_rdy <= {t_rdy[1:0], lane_tx_ready_in};
            if (t_rdy[1] == t_rdy[2]) t_en <= t_rdy[2];
        end
    end

    always_ff @(posedge lane_tx_clock_in) begin
        if (!t_rst[2] || !t_en) begin
            lane_tx_word_out <= sfc_pkg::COMMA_WORD;
            prbs             <= sfc_pkg::PRBS_SEED;
            gap              <= 4'h0;
        end else begin
            gap  <= gap + 4'h1;
            prbs <= {prbs[5:0], prbs[6] ^ prbs[5]};
            if (gap == sfc_pkg::COMMA_GAP) lane_tx_word_out <= sfc_pkg::COMMA_WORD;
            else lane_tx_word_out <= {10'h000, 3'h0, prbs, 10'h000, 3'h0, prbs};
        end
    end

    // Assertions
    property p_pcs_after_hard;
        @(posedge clk_in) disable iff (!rst_n_in)
        $rose(rx_pcs_reset_n_out) |-> pma_hard_reset_n_out && $past(pma_hard_reset_n_out, 8);
    endproperty
    a_pcs_after_hard: assert property (p_pcs_after_hard) else $error("PCS reset released too early");

    property p_pcs_same;
        @(posedge clk_in) disable iff (!rst_n_in)
        rx_pcs_reset_n_out == tx_pcs_reset_n_out;
    endproperty
    a_pcs_same: assert property (p_pcs_same) else $error("PCS resets differ");

    property p_power_first;
        @(posedge clk_in) disable iff (!rst_n_in)
        pma_hard_reset_n_out |-> !rx_power_on_n_out == 1'b0 && synth_power_on_n_out;
    endproperty
    a_power_first: assert property (p_power_first) else $error("Hard reset released before power on");

    property p_req_done;
        @(posedge clk_in) disable iff (!rst_n_in)
        $rose(pass_out.req) |-> $past(done_st);
    endproperty
    a_req_done: assert property (p_req_done) else $error("Request raised without done");

    property p_req_fields;
        @(posedge clk_in) disable iff (!rst_n_in)
        pass_out.req |=> pass_out.addr == $past(addr_reg);
    endproperty
    a_req_fields: assert property (p_req_fields) else $error("Pass address mismatch");

    property p_capture;
        @(posedge clk_in) disable iff (!rst_n_in)
        valid_st && !valid_q |=> rdata_reg == $past(pass_rdata_in, 4);
    endproperty
    a_capture: assert property (p_capture) else $error("Read data not captured");

    property p_lbdis;
        @(posedge clk_in) disable iff (!rst_n_in)
        $rose(ctrl[sfc_pkg::CTRL_LBDIS_BIT]) |=> loopback_disable_out;
    endproperty
    a_lbdis: assert property (p_lbdis) else $error("Loopback disable not driven");

    property p_comma_off;
        @(posedge lane_tx_clock_in)
        !t_rst[2] |=> lane_tx_word_out == sfc_pkg::COMMA_WORD;
    endproperty
    a_comma_off: assert property (p_comma_off) else $error("Comma missing in reset");
endmodule // sfc_ctrl

// ==== bench/sfc_lane_model.sv ====
// Behavioural lane hard block plus loopback controller, far side of sfc_ctrl.
// Assumes all status is timed on the system clock; the lane makes its TX clock.
`timescale 1ns/1ps
module sfc_lane_model #(
    // Pass-through enable of the loopback controller
    parameter bit PASS_EN = 1'b1
) (
    // Clock
    input  wire logic                clk_in,
    // Resets, power and loopback control from the controller
    input  wire logic                pma_hard_reset_n_in,
    input  wire logic                rx_pcs_reset_n_in,
    input  wire logic                tx_pcs_reset_n_in,
    input  wire logic                rx_power_on_n_in,
    input  wire logic                synth_power_on_n_in,
    input  wire logic                tx_power_on_n_in,
    input  wire logic                loopback_disable_in,
    input  wire sfc_pkg::sfc_pass_t  pass_in,
    // Status and clock toward the controller
    output logic                     lane_tx_clock_out,
    output sfc_pkg::sfc_ready_t      ready_out,
    output logic                     lb_done_out,
    output logic                     pass_valid_out,
    output logic [15:0]              pass_rdata_out,
    output logic                     loopback_on_out
);
    logic               req_q;
    logic               dis_q;
    logic [3:0]         wait_cnt;
    logic [7:0]         prog_cnt;
    logic [15:0]        store_q;
    sfc_pkg::sfc_pass_t acc_q;

    initial lane_tx_clock_out = 1'b0;
    always #80 lane_tx_clock_out = ~lane_tx_clock_out;

    // Ready status from resets and power
    always_ff @(posedge clk_in) begin
        ready_out.synth <= pma_hard_reset_n_in & synth_power_on_n_in;
        ready_out.tx    <= pma_hard_reset_n_in & tx_pcs_reset_n_in & tx_power_on_n_in;
        ready_out.rx    <= pma_hard_reset_n_in & rx_pcs_reset_n_in & rx_power_on_n_in;
        ready_out.align <= ready_out.rx;
    end

    // Loopback programming and disable
    always_ff @(posedge clk_in) begin
        dis_q <= loopback_disable_in;
        if (!(ready_out.synth & ready_out.tx & ready_out.rx)) begin
            prog_cnt        <= 8'h00;
            lb_done_out     <= 1'b0;
            loopback_on_out <= 1'b0;
        end else if (prog_cnt != 8'h20) begin
            prog_cnt        <= prog_cnt + 8'h01;
            loopback_on_out <= (prog_cnt == 8'h1F);
            lb_done_out     <= (prog_cnt == 8'h1F);
        end else if (loopback_disable_in && !dis_q) begin
            loopback_on_out <= 1'b0;
        end
    end

    // Pass-through accesses; read data is held for the pulse only
    always_ff @(posedge clk_in) begin
        req_q          <= pass_in.req;
        pass_valid_out <= 1'b0;
        pass_rdata_out <= ~pass_rdata_out;
        if (PASS_EN && pass_in.req && !req_q && lb_done_out) begin
            acc_q    <= pass_in;
            wait_cnt <= 4'h6;
        end else if (wait_cnt == 4'h1) begin
            wait_cnt       <= 4'h0;
            pass_valid_out <= 1'b1;
            if (acc_q.write) begin
                store_q <= acc_q.wdata;
            end else begin
                pass_rdata_out <= store_q ^ acc_q.addr ^ {15'h0000, acc_q.pma};
            end
        end else if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
        end
    end
endmodule // sfc_lane_model

// ==== bench/sfc_ctrl_bench.sv ====
// Self-checking bench for sfc_ctrl: APB tasks drive it, the lane model answers.
// Assumes sfc_lane_model stands on the far side of the lane pins.
`timescale 1ns/1ps
module sfc_ctrl_bench;
    logic                clk_in = 1'b0;
    logic                rst_n_in = 1'b0;
    logic                psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata, rd;
    logic                hard_n, rxr_n, txr_n, rxp_n, syp_n, txp_n, tx_clk, lb_dis, done, valid, lb_on;
    logic [39:0]         word;
    logic [15:0]         rdata16;
    sfc_pkg::sfc_pass_t  pass;
    sfc_pkg::sfc_ready_t rdy;
    int                  fails = 0;
    int                  checks = 0;
    int                  n;

    always #2.5 clk_in = ~clk_in;

    sfc_ctrl i_sfc_ctrl (.clk_in(clk_in), .rst_n_in(rst_n_in), .lane_tx_clock_in(tx_clk),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .pma_hard_reset_n_out(hard_n),
        .rx_pcs_reset_n_out(rxr_n), .tx_pcs_reset_n_out(txr_n), .rx_power_on_n_out(rxp_n),
        .synth_power_on_n_out(syp_n), .tx_power_on_n_out(txp_n), .lane_tx_ready_in(rdy.tx),
        .lane_synth_ready_in(rdy.synth), .lane_rx_ready_in(rdy.rx), .align_locked_in(rdy.align),
        .lane_tx_word_out(word), .loopback_disable_out(lb_dis), .pass_out(pass), .lb_done_in(done),
        .pass_valid_in(valid), .pass_rdata_in(rdata16));

    sfc_lane_model i_sfc_lane_model (.clk_in(clk_in), .pma_hard_reset_n_in(hard_n),
        .rx_pcs_reset_n_in(rxr_n), .tx_pcs_reset_n_in(txr_n), .rx_power_on_n_in(rxp_n),
        .synth_power_on_n_in(syp_n), .tx_power_on_n_in(txp_n), .loopback_disable_in(lb_dis),
        .pass_in(pass), .lane_tx_clock_out(tx_clk), .ready_out(rdy), .lb_done_out(done),
        .pass_valid_out(valid), .pass_rdata_out(rdata16), .loopback_on_out(lb_on));

    task automatic check(input string name, input logic [39:0] exp, input logic [39:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic results();
        $display("Counts: %0d checks, %0d mismatches", checks, fails);
        if (fails == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_in);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
            k++;
        end while (pready !== 1'b1 && k < 100);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 100) begin
            fails++;
            results();
        end
    endtask

    task automatic poll(input int b, input logic v);
        int k;
        for (k = 0; k < 300; k++) begin
            apb(1'b0, sfc_pkg::STATUS_OFS, 32'h0000_0000);
            if (rd[b] === v) break;
        end
        if (k == 300) begin
            fails++;
            results();
        end
    endtask

    task automatic access(input logic [31:0] ctl, input logic [15:0] a, input logic [15:0] exp);
        int k;
        apb(1'b1, sfc_pkg::ADDR_OFS, {16'h0000, a});
        apb(1'b1, sfc_pkg::CTRL_OFS, ctl);
        for (k = 0; k < 100 && pass.req !== 1'b1; k++) @(posedge clk_in);
        check("pass request", {1'b1, ctl[3], ctl[4], a, 16'hBEEF}, pass);
        for (k = 0; k < 100 && valid !== 1'b1; k++) @(posedge clk_in);
        if (k == 100) begin
            fails++;
            results();
        end
        @(posedge clk_in);
        check("complete pulse", 1'b0, valid);
        poll(9, 1'b0);
        apb(1'b0, sfc_pkg::RDATA_OFS, 32'h0000_0000);
        if (!ctl[3]) check("read data", exp, rd[15:0]);
        apb(1'b1, sfc_pkg::CTRL_OFS, 32'h0000_0001);
    endtask

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        check("lane pins idle", 6'h00, {hard_n, rxr_n, txr_n, rxp_n, syp_n, txp_n});
        apb(1'b0, sfc_pkg::CTRL_OFS, 32'h0000_0000);
        check("ctrl reset", 32'h0000_0000, rd);
        apb(1'b0, 8'h14, 32'h0000_0000);
        check("unmapped error", 1'b1, err);
        @(posedge tx_clk);
        #1 check("comma idle", sfc_pkg::COMMA_WORD, word);
        $display("Reset test done");
        apb(1'b1, sfc_pkg::CTRL_OFS, 32'h0000_0001);
        repeat (150) @(posedge clk_in);
        check("power early", 3'h0, {rxp_n, syp_n, txp_n});
        repeat (100) @(posedge clk_in);
        check("power on", {3'h7, 1'b0}, {rxp_n, syp_n, txp_n, hard_n});
        repeat (200) @(posedge clk_in);
        check("hard released", 3'h4, {hard_n, rxr_n, txr_n});
        repeat (200) @(posedge clk_in);
        check("pcs released", 3'h7, {hard_n, rxr_n, txr_n});
        $display("Sequence test done");
        for (n = 0; n < 40 && word === sfc_pkg::COMMA_WORD; n++) @(posedge tx_clk);
        n = 0;
        repeat (48) begin
            @(posedge tx_clk);
            #1 if (word === sfc_pkg::COMMA_WORD) n++;
        end
        check("commas in stream", 1'b1, n >= 2 && n <= 4);
        $display("Stream test done");
        poll(8, 1'b1);
        check("ready bits", 4'hF, rd[7:4]);
        check("loopback on", 1'b1, lb_on);
        apb(1'b1, sfc_pkg::WDATA_OFS, 32'h0000_BEEF);
        access(32'h0000_001D, 16'h1234, 16'h0000);
        for (int i = 0; i < 2; i++) begin
            access(32'h0000_0005 | (i << 4), 16'hABCD, 16'hBEEF ^ 16'hABCD ^ 16'(i));
        end
        $display("Pass-through test done");
        apb(1'b1, sfc_pkg::CTRL_OFS, 32'h0000_0003);
        for (n = 0; n < 50 && lb_on !== 1'b0; n++) @(posedge clk_in);
        check("loopback off", 2'b10, {lb_dis, lb_on});
        $display("Loopback test done");
        results();
    end
endmodule // sfc_ctrl_bench
